// ### dv/pitpc_pulse_src.sv
// pitpc_pulse_src: external pulse source on the accumulator input pin.
// assumes the bench calls its tasks; the pin idles low.
`timescale 1ns/1ps
module pitpc_pulse_src (
    // clock
    input  wire logic core_clk,
    // pin
    output logic      pin
);
    initial pin = 1'b0;
    task automatic level(input logic v, input int hold);
        int n;
        n = (hold < 2) ? 2 : hold;
        @(posedge core_clk);
        pin <= v;
        repeat (n - 1) @(posedge core_clk);
    endtask
    task automatic pulses(input int cnt, input int hold);
        repeat (cnt) begin
            level(1'b1, hold);
            level(1'b0, hold);
        end
    endtask
endmodule

// ### dv/pitpc_top_asserts.sv
// pitpc_top_asserts: port-level checks on pitpc_top.
// assumes it is bound to pitpc_top and sees its ports only.
`timescale 1ns/1ps
module pitpc_top_asserts
    import pitpc_pkg::*;
#(
    parameter int BASE_EXP = PERIODIC_BASE_EXP,
    parameter int DIV_GATE = GATED_DIV
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       clkEn,
    // register port
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrStb,
    input  wire logic       regRdStb,
    input  wire logic [7:0] regRdData,
    // events and outputs
    input  wire logic       mainCounterWrap,
    input  wire logic       timerIrq,
    input  wire logic       periodicInterrupt,
    input  wire logic       port7Direction,
    input  wire logic       port3Direction,
    input  wire logic       capture4Compare5Select
);
    logic [7:0] enReg;
    logic [7:0] ctrlReg;
    logic       wrOk;
    logic       rdOk;
    assign wrOk = regWrStb && clkEn;
    assign rdOk = regRdStb && clkEn;
    // shadows of the two plain read-write registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            enReg   <= 8'h00;
            ctrlReg <= 8'h00;
        end else begin
            if (wrOk && regAddr == OFS_IRQ_ENABLE) begin
                enReg <= regWrData;
            end
            if (wrOk && regAddr == OFS_PULSE_CTRL) begin
                ctrlReg <= regWrData;
            end
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_per_en: assert property (periodicInterrupt |-> enReg[6])
        else $error("periodic request without enable");
    a_per_irq: assert property (periodicInterrupt |-> timerIrq)
        else $error("periodic request missing on irq");
    a_wrap_irq: assert property (mainCounterWrap && clkEn && enReg[7]
        && !regWrStb |=> timerIrq)
        else $error("wrap did not raise irq");
    a_rd_unmap: assert property (rdOk && (regAddr < 8'h24
        || regAddr > 8'h27) |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_rd_enable: assert property (rdOk && regAddr == OFS_IRQ_ENABLE
        |=> regRdData == (enReg & MASK_IRQ_ENABLE))
        else $error("enable readback wrong");
    a_rd_ctrl: assert property (rdOk && regAddr == OFS_PULSE_CTRL
        |=> regRdData == ctrlReg)
        else $error("control readback wrong");
    a_flag_low: assert property (rdOk && regAddr == OFS_EVENT_FLAGS
        |=> regRdData[3:0] == 4'h0)
        else $error("flag low bits not zero");
    a_dir_out: assert property ({port7Direction, port3Direction,
        capture4Compare5Select} == {ctrlReg[7], ctrlReg[3], ctrlReg[2]})
        else $error("direction outputs differ from control");
    a_rst_quiet: assert property ($fell(rst) |-> !timerIrq
        && regRdData == 8'h00)
        else $error("outputs busy after reset");
    cover property ($rose(periodicInterrupt));
    cover property (rdOk && regAddr == OFS_PULSE_COUNT);
    cover property (mainCounterWrap && enReg[7]);
endmodule

// ### dv/pitpc_top_test.sv
// pitpc_top_test: self-checking bench for pitpc_top.
// assumes pitpc_pulse_src drives the pin; the checker is bound below.
`timescale 1ns/1ps
module pitpc_top_test;
    import pitpc_pkg::*;
    localparam int BASE_EXP = 4;
    localparam int DIV_GATE = 4;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       clkEn = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic       regWrStb = 1'b0;
    logic       regRdStb = 1'b0;
    logic [7:0] regRdData;
    logic       mainCounterWrap = 1'b0;
    logic       pin;
    logic       timerIrq;
    logic       periodicInterrupt;
    logic [1:0] prescale;
    logic [7:0] rdv;
    int         n_fail = 0;
    int         comparisons = 0;
    int         cyc = 0;
    int         t0;
    logic [7:0] evCtrl [3] = '{8'hc3, 8'h53, 8'h03};
    logic [7:0] evCnt [3] = '{8'h01, 8'h01, 8'hfe};
    logic [7:0] evFlg [3] = '{8'h30, 8'h30, 8'h00};
    logic [7:0] gtCtrl [4] = '{8'h63, 8'h73, 8'h63, 8'h73};
    logic       gtPin [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    pitpc_top #(.BASE_EXP(BASE_EXP), .DIV_GATE(DIV_GATE)) dut_u (
        .core_clk, .rst, .clkEn, .regAddr, .regWrData, .regWrStb,
        .regRdStb, .regRdData, .mainCounterWrap,
        .accumulatorInputPin(pin), .timerIrq, .periodicInterrupt,
        .port7Direction(), .port3Direction(),
        .capture4Compare5Select(), .timerPrescaleSelect(prescale));
    pitpc_pulse_src src_u (.core_clk, .pin);
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge core_clk);
        regWrStb <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] m,
                       input logic [7:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge core_clk);
        regRdStb <= 1'b0;
        @(posedge core_clk);
        rdv = regRdData;
        chk(rdv & m, exp);
    endtask
    task automatic wait_per();
        int k;
        k = 0;
        while (periodicInterrupt !== 1'b1 && k < 300) begin
            @(posedge core_clk);
            #1;
            k++;
        end
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        #1 t0 = cyc;
        wr(OFS_IRQ_ENABLE, 8'hff);
        wait_per();
        chk({7'h0, ((cyc - t0) inside {[16:19]})}, 8'h01);
        rdc(OFS_IRQ_ENABLE, 8'hff, 8'hf3);
        chk({6'h0, prescale}, 8'h03);
        for (int r = 0; r < 4; r++) begin
            wr(OFS_PULSE_CTRL, 8'(r));
            wr(OFS_EVENT_FLAGS, 8'h40);
            wait_per();
            t0 = cyc;
            wr(OFS_EVENT_FLAGS, 8'hbf);
            chk({7'h0, periodicInterrupt}, 8'h01);
            wr(OFS_EVENT_FLAGS, 8'h40);
            chk({7'h0, periodicInterrupt}, 8'h00);
            wait_per();
            chk(8'(cyc - t0), 8'(16 << r));
        end
        wr(OFS_EVENT_FLAGS, 8'hf0);
        @(posedge core_clk);
        mainCounterWrap <= 1'b1;
        @(posedge core_clk);
        mainCounterWrap <= 1'b0;
        rdc(OFS_EVENT_FLAGS, 8'h80, 8'h80);
        chk({7'h0, timerIrq}, 8'h01);
        wr(OFS_EVENT_FLAGS, 8'h80);
        rdc(OFS_EVENT_FLAGS, 8'h8f, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_PULSE_CTRL, evCtrl[i]);
            wr(OFS_PULSE_COUNT, 8'hfe);
            wr(OFS_EVENT_FLAGS, 8'h30);
            src_u.pulses(3, 3);
            repeat (4) @(posedge core_clk);
            rdc(OFS_PULSE_COUNT, 8'hff, evCnt[i]);
            rdc(OFS_EVENT_FLAGS, 8'h30, evFlg[i]);
        end
        for (int i = 0; i < 4; i++) begin
            src_u.level(gtPin[i], 4);
            wr(OFS_PULSE_CTRL, gtCtrl[i]);
            wr(OFS_PULSE_COUNT, 8'h00);
            src_u.level(gtPin[i], 40);
            // counting cases hold 10 or 11 ticks: only the upper nibble
            // is exact there, the range check below covers the rest
            rdc(OFS_PULSE_COUNT, (i % 3 == 0) ? 8'hf0 : 8'hff,
                8'h00);
            chk({7'h0, (rdv inside {[8'd9:8'd12]}) == (i % 3 == 0)},
                8'h01);
        end
        wr(OFS_PULSE_CTRL, 8'h00);
        wr(OFS_PULSE_COUNT, 8'h5a);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rdc(OFS_PULSE_COUNT, 8'hff, 8'h5a);
        chk({7'h0, timerIrq}, 8'h00);
        // writes are ignored while the clock enable is low
        clkEn <= 1'b0;
        wr(OFS_PULSE_COUNT, 8'h11);
        @(posedge core_clk);
        clkEn <= 1'b1;
        rdc(OFS_PULSE_COUNT, 8'hff, 8'h5a);
        for (int a = 8'h24; a < 8'h27; a++) begin
            rdc(8'(a), 8'hff, 8'h00);
        end
        rdc(8'h30, 8'hff, 8'h00);
        print_verdict();
    end
endmodule

bind pitpc_top pitpc_top_asserts #(
    .BASE_EXP(BASE_EXP), .DIV_GATE(DIV_GATE)) chk_u (
    .core_clk, .rst, .clkEn, .regAddr, .regWrData, .regWrStb, .regRdStb,
    .regRdData, .mainCounterWrap, .timerIrq, .periodicInterrupt,
    .port7Direction, .port3Direction, .capture4Compare5Select);

// ### hdl/pitpc_input_sync.sv
// pitpc_input_sync: two-stage synchroniser and edge detect for the
// accumulator input pin.
// assumes the pin is asynchronous to core_clk.
`timescale 1ns/1ps
module pitpc_input_sync (
    // clock and reset
    input  wire logic     core_clk,
    input  wire logic     rst,
    input  wire logic     clkEn,
    // pin
    input  wire logic     accumulatorInputPin,
    // events
    pitpc_link_if.sync    link
);
    typedef struct packed {
        logic meta;
        logic level;
        logic last;
    } pitpc_sync_s;

    pitpc_sync_s state_reg;
    pitpc_sync_s state_next;

    always_comb begin
        state_next       = state_reg;
        state_next.meta  = accumulatorInputPin;
        state_next.level = state_reg.meta;
        state_next.last  = state_reg.level;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= '0;
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end

    assign link.inputLevel = state_reg.level;
    assign link.riseSeen   = clkEn & state_reg.level & ~state_reg.last;
    assign link.fallSeen   = clkEn & ~state_reg.level & state_reg.last;
endmodule

// ### hdl/pitpc_link_if.sv
// pitpc_link_if: carries tick and edge events from the helpers to the top.
// assumes all parties share core_clk.
`timescale 1ns/1ps
interface pitpc_link_if;
    logic       periodicTick;
    logic [1:0] rateSelect;
    logic       inputLevel;
    logic       riseSeen;
    logic       fallSeen;

    modport divider (input rateSelect, output periodicTick);
    modport topDiv  (output rateSelect, input periodicTick);
    modport sync    (output inputLevel, riseSeen, fallSeen);
    modport topSync (input inputLevel, riseSeen, fallSeen);
endinterface

// ### hdl/pitpc_periodic_div.sv
// pitpc_periodic_div: free-running divider giving the periodic timeout.
// assumes rst is synchronous to core_clk; only rst restarts it.
`timescale 1ns/1ps
module pitpc_periodic_div
    import pitpc_pkg::*;
#(
    parameter int BASE_EXP = PERIODIC_BASE_EXP
) (
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire logic          clkEn,
    // events
    pitpc_link_if.divider      link
);
    localparam int W = BASE_EXP + 3;

    typedef struct packed {
        logic [W-1:0] count;
        logic         tick;
    } pitpc_div_s;

    pitpc_div_s state_reg;
    pitpc_div_s state_next;

    // timeout when the low BASE_EXP+rate bits all roll to zero
    function automatic logic rollOver(logic [W-1:0] c, logic [1:0] r);
        logic [W-1:0] m;
        m = (W'(1) << (BASE_EXP + int'(r))) - W'(1);
        return (c & m) == m;
    endfunction

    always_comb begin
        state_next       = state_reg;
        state_next.count = state_reg.count + W'(1);
        // first tick after one whole period; spacing set by the counter
        state_next.tick  = rollOver(state_reg.count, link.rateSelect);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= '0;
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end

    assign link.periodicTick = state_reg.tick & clkEn;
endmodule

// ### hdl/pitpc_pkg.sv
// pitpc_pkg: register map, field positions, reset values and timing
// counts shared by the periodic tick and pulse counter block.
// assumes an 8-bit register port with byte addresses.
package pitpc_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h24;
    localparam logic [7:0] OFS_EVENT_FLAGS = 8'h25;
    localparam logic [7:0] OFS_PULSE_CTRL  = 8'h26;
    localparam logic [7:0] OFS_PULSE_COUNT = 8'h27;

    // reset values
    localparam logic [7:0] RST_IRQ_ENABLE  = 8'h00;
    localparam logic [7:0] RST_EVENT_FLAGS = 8'h00;
    localparam logic [7:0] RST_PULSE_CTRL  = 8'h00;

    // flag and enable bit positions (same in both registers)
    localparam int BIT_OVERFLOW    = 7;
    localparam int BIT_PERIODIC    = 6;
    localparam int BIT_PULSE_OVF   = 5;
    localparam int BIT_INPUT_EDGE  = 4;

    // implemented bits of the enable and flag registers
    localparam logic [7:0] MASK_IRQ_ENABLE  = 8'hf3;
    localparam logic [7:0] MASK_EVENT_FLAGS = 8'hf0;
    localparam logic [7:0] MASK_IRQ_SOURCES = 8'hf0;

    // pulse control fields
    localparam int BIT_PORT7_DIR   = 7;
    localparam int BIT_PULSE_EN    = 6;
    localparam int BIT_PULSE_MODE  = 5;
    localparam int BIT_PULSE_EDGE  = 4;
    localparam int BIT_PORT3_DIR   = 3;
    localparam int BIT_CAP4_CMP5   = 2;
    localparam int LSB_RATE_SELECT = 0;

    // timing: base periodic divider exponent and gated divider
    localparam int PERIODIC_BASE_EXP = 13;
    localparam int GATED_DIV         = 64;
    localparam int GATED_DIV_W       = $clog2(GATED_DIV);

endpackage

// ### hdl/pitpc_top.sv
// pitpc_top: periodic interrupt generator and 8-bit pulse counter with
// its enable, flag and control registers.
// assumes a single-cycle register port on core_clk; read data one cycle
// after the read strobe; the main counter wrap arrives as a pulse.
//
// Functional notes
// - rate select codes 0..3 give periods of 2^13..2^16 clocks
// - periodic divider uses a 2^13 base independent of timer prescaler
// - periodic divider runs freely; only reset restarts it
// - period counts from previous timeout, not from flag clear
// - each timeout sets periodic flag; request when flag and enable set
// - first periodic flag only after one full period from reset
// - writing one to a flag bit clears it; zeros leave it
// - main counter wrap sets the overflow flag
// - upper four enable bits gate requests of matching flags
// - 8-bit pulse counter; mode bit picks event or gated counting
// - pulse counting happens only while the enable bit is one
// - event mode counts falling edge, or rising when edge bit is one
// - gated mode counts on a free-running clock/64 while input active
// - gated mode: edge bit zero, low inhibits; one, high inhibits
// - software may read or write the pulse counter any time
// - pin keeps feeding the counter even when driven as output
// - counter rollover from all ones to zero sets pulse overflow flag
// - selected input edge sets the input edge flag while the enable bit is one
// - reset leaves the pulse counter value unchanged
`timescale 1ns/1ps
module pitpc_top
    import pitpc_pkg::*;
#(
    parameter int BASE_EXP = PERIODIC_BASE_EXP,
    parameter int DIV_GATE = GATED_DIV
) (
    // clock, reset, enable
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       clkEn,
    // register port
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrStb,
    input  wire logic       regRdStb,
    output logic      [7:0] regRdData,
    // timer system
    input  wire logic       mainCounterWrap,
    // pin
    input  wire logic       accumulatorInputPin,
    // outputs
    output logic            timerIrq,
    output logic            periodicInterrupt,
    output logic            port7Direction,
    output logic            port3Direction,
    output logic            capture4Compare5Select,
    output logic      [1:0] timerPrescaleSelect
);
    localparam int DW = $clog2(DIV_GATE);

    typedef struct packed {
        logic [7:0]    irqEnable;
        logic [7:0]    flags;
        logic [7:0]    ctrl;
        logic [DW-1:0] gateDiv;
        logic [7:0]    rdData;
    } pitpc_state_s;

    pitpc_state_s state_reg;
    pitpc_state_s state_next;
    // the count is outside the reset struct: reset must not touch it
    logic [7:0]   pulseCount_reg;
    logic [7:0]   pulseCount_next;

    pitpc_link_if link ();

    pitpc_periodic_div #(
        .BASE_EXP (BASE_EXP)
    ) uDiv (
        .core_clk (core_clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .link     (link.divider)
    );

    pitpc_input_sync uSync (
        .core_clk            (core_clk),
        .rst                 (rst),
        .clkEn               (clkEn),
        .accumulatorInputPin (accumulatorInputPin),
        .link                (link.sync)
    );

    assign link.rateSelect = state_reg.ctrl[LSB_RATE_SELECT +: 2];

    function automatic logic hit(logic [7:0] a, logic [7:0] ofs);
        return a == ofs;
    endfunction

    logic pulseEnable;
    logic pulseMode;
    logic edgeSel;
    logic edgeEvent;
    logic gateOpen;
    logic gateTick;
    logic countStep;
    logic [7:0] setMask;
    logic [7:0] clrMask;

    always_comb begin
        pulseEnable = state_reg.ctrl[BIT_PULSE_EN];
        pulseMode   = state_reg.ctrl[BIT_PULSE_MODE];
        edgeSel     = state_reg.ctrl[BIT_PULSE_EDGE];
        // selected edge: rising when edge bit one, else falling
        edgeEvent   = edgeSel ? link.riseSeen : link.fallSeen;
        // active level is the opposite of the inhibiting one
        gateOpen    = link.inputLevel == edgeSel ? 1'b0 : 1'b1;
        gateTick    = clkEn && (state_reg.gateDiv == DW'(DIV_GATE - 1));
        countStep   = pulseEnable && (pulseMode ? (gateTick && gateOpen)
                                               : edgeEvent);

        setMask = 8'h00;
        setMask[BIT_OVERFLOW]   = mainCounterWrap & clkEn;
        setMask[BIT_PERIODIC]   = link.periodicTick;
        setMask[BIT_INPUT_EDGE] = pulseEnable & edgeEvent;
        setMask[BIT_PULSE_OVF]  = countStep && pulseCount_reg == 8'hff;

        clrMask = 8'h00;
        if (regWrStb && clkEn && hit(regAddr, OFS_EVENT_FLAGS)) begin
            clrMask = regWrData & MASK_EVENT_FLAGS;
        end

        state_next = state_reg;
        state_next.gateDiv = state_reg.gateDiv + DW'(1);
        // set wins over a clear in the same cycle
        state_next.flags = ((state_reg.flags & ~clrMask) | setMask)
                           & MASK_EVENT_FLAGS;

        pulseCount_next = pulseCount_reg;
        if (countStep) begin
            pulseCount_next = pulseCount_reg + 8'h01;
        end

        if (regWrStb) begin
            if (hit(regAddr, OFS_IRQ_ENABLE)) begin
                state_next.irqEnable = regWrData & MASK_IRQ_ENABLE;
            end
            if (hit(regAddr, OFS_PULSE_CTRL)) begin
                state_next.ctrl = regWrData;
            end
            if (hit(regAddr, OFS_PULSE_COUNT)) begin
                pulseCount_next = regWrData;
            end
        end

        state_next.rdData = state_reg.rdData;
        if (regRdStb) begin
            unique case (regAddr)
                OFS_IRQ_ENABLE:  state_next.rdData = state_reg.irqEnable;
                OFS_EVENT_FLAGS: state_next.rdData = state_reg.flags;
                OFS_PULSE_CTRL:  state_next.rdData = state_reg.ctrl;
                OFS_PULSE_COUNT: state_next.rdData = pulseCount_reg;
                default:         state_next.rdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg.irqEnable <= RST_IRQ_ENABLE;
            state_reg.flags     <= RST_EVENT_FLAGS;
            state_reg.ctrl      <= RST_PULSE_CTRL;
            state_reg.gateDiv   <= '0;
            state_reg.rdData    <= 8'h00;
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clkEn) begin
            pulseCount_reg <= pulseCount_next;
        end
    end

    assign regRdData = state_reg.rdData;
    // each of the upper four enable bits gates its own flag
    assign timerIrq  = |(state_reg.flags & state_reg.irqEnable
                         & MASK_IRQ_SOURCES);
    assign periodicInterrupt = state_reg.flags[BIT_PERIODIC]
                               & state_reg.irqEnable[BIT_PERIODIC];
    assign port7Direction         = state_reg.ctrl[BIT_PORT7_DIR];
    assign port3Direction         = state_reg.ctrl[BIT_PORT3_DIR];
    assign capture4Compare5Select = state_reg.ctrl[BIT_CAP4_CMP5];
    assign timerPrescaleSelect    = state_reg.irqEnable[1:0];
endmodule
